// [verification/pll_ref_monitor.sv]
`timescale 1ns/1ps
module pll_ref_monitor
  import pll_ref_pkg::*;
(
  input wire logic              clock,               // Clock
  input wire logic              srst,                // Reset
  input wire logic              reg_wr,              // Write
  input wire logic              reg_rd,              // Read
  input wire logic [ADDR_W-1:0] reg_addr,            // Offset
  input wire logic [7:0]        reg_wdata,           // Wdata
  input wire logic [7:0]        reg_rdata,           // Rdata
  input wire logic              pll_power_down,      // PLL off
  input wire logic              primary_reference,   // Ref one
  input wire logic              secondary_reference, // Ref two
  input wire logic              sync_n,              // Align
  input wire buf_power_t        buf_power,           // Buffers
  input wire logic              active_is_secondary, // Active
  input wire logic              primary_missing,     // Missing
  input wire logic              pfd_reference,       // R out
  input wire logic              pfd_feedback,        // N out
  input wire logic              cp_high_z            // Hold
);
  logic [7:0] ctl_q, syn_q, pre_q;
  logic [1:0] fall_q;
  logic [2:0] rise_q;
  logic [3:0] hold_q;
  logic       p_q, s_q, held;

  assign held = pre_q[PRE_CNT_RESET] || (!sync_n && syn_q[7:6] != 2'h0);

  // Shadow the control bytes and count monitor edges as raw samples
  always_ff @(posedge clock) begin
    p_q <= primary_reference;
    s_q <= secondary_reference;
    if (srst) begin
      ctl_q <= RST_REF_INPUT;
      syn_q <= RST_SYNC_DELAY;
      pre_q <= RST_PRESCALER;
      fall_q <= 2'h0;
      rise_q <= 3'h0;
      hold_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_REF_INPUT) ctl_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_SYNC_DELAY) syn_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_PRESCALER) pre_q <= reg_wdata;
      if (primary_reference != p_q)
        fall_q <= {1'b0, s_q && !secondary_reference};
      else if (s_q && !secondary_reference && fall_q != 2'h3)
        fall_q <= fall_q + 2'h1;
      if (!primary_missing)
        rise_q <= 3'h0;
      else if (primary_reference && !p_q && rise_q != 3'h7)
        rise_q <= rise_q + 3'h1;
      if (!held) hold_q <= 4'h0;
      else if (hold_q != 4'hF) hold_q <= hold_q + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_pd_off;
    pll_power_down ##1 pll_power_down |-> buf_power == 3'b000;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("buffer on in PLL off");
  property p_diff_excl;
    buf_power.diff |-> !buf_power.prim && !buf_power.sec;
  endproperty
  a_diff_excl: assert property (p_diff_excl)
    else $error("single on in diff");
  property p_en_cause;
    $rose(buf_power.diff || buf_power.prim || buf_power.sec) |->
      $past(reg_wr && reg_addr == ADDR_REF_INPUT, 2) || $past(pll_power_down, 2);
  endproperty
  a_en_cause: assert property (p_en_cause)
    else $error("buffer on uncaused");
  property p_miss_cause;
    $rose(primary_missing) |-> fall_q >= 2'h2;
  endproperty
  a_miss_cause: assert property (p_miss_cause)
    else $error("early missing");
  property p_miss_clear;
    $fell(primary_missing) |-> rise_q >= 3'h4;
  endproperty
  a_miss_clear: assert property (p_miss_clear)
    else $error("early return");
  property p_sec_align;
    $rose(active_is_secondary) && !ctl_q[RIC_DEGL_DIS] |->
      secondary_reference || $past(secondary_reference);
  endproperty
  a_sec_align: assert property (p_sec_align)
    else $error("misaligned");
  property p_hold_quiet;
    hold_q >= 4'hC |-> !pfd_reference && !pfd_feedback;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("pulse in reset");
  property p_cp_enter;
    $rose(cp_high_z) |-> !$past(sync_n);
  endproperty
  a_cp_enter: assert property (p_cp_enter)
    else $error("hold uncaused");
  property p_cp_leave;
    $fell(cp_high_z) |-> $past(sync_n);
  endproperty
  a_cp_leave: assert property (p_cp_leave)
    else $error("hold left early");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
endmodule

// [verification/pll_ref_select_and_dividers_tb.sv]
`timescale 1ns/1ps
module pll_ref_select_and_dividers_tb;
  import pll_ref_pkg::*;
  localparam int PH = 3;
  localparam int VH = 2;

  logic              clock, srst, reg_wr, reg_rd, pll_power_down;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata;
  logic              ref_select_pin, sync_n, prim_en, sec_en;
  logic              primary_reference, secondary_reference, vco_clock;
  logic [5:0]        a_count;
  logic [12:0]       b_count;
  buf_power_t        buf_power;
  logic              active_is_secondary, primary_missing;
  logic              pfd_reference, pfd_feedback, cp_high_z;
  logic [2:0]        st;
  int                error_cnt, n_checks;

  assign st = {cp_high_z, primary_missing, active_is_secondary};

  pll_ref_select_and_dividers dut_u (.*);

  ref_clk_model #(.PH(PH), .SH(4), .VH(VH)) src_u (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    chk(reg_rdata, e);
  endtask

  // Status bit s: 0 active secondary, 1 missing, 2 charge pump held
  task automatic wait_for(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (k < lim && st[s] !== v) begin
      tick(1);
      k++;
    end
    chk(st[s], v);
    if (k == lim) wrap_up();
  endtask

  // Spacing of the last two of three pulses on the chosen divider output
  task automatic period(input logic fb, output int n);
    int k, p, last;
    p = 0;
    last = 0;
    n = 0;
    for (k = 0; k < 5000 && p < 3; k++) begin
      tick(1);
      if ((fb ? pfd_feedback : pfd_reference) === 1'b1) begin
        p++;
        n = k - last;
        last = k;
      end
    end
    if (p < 3) begin
      chk(p, 3);
      wrap_up();
    end
  endtask

  task automatic pulses(output int r);
    r = 0;
    repeat (60) begin
      tick(1);
      r += int'(pfd_reference === 1'b1) + int'(pfd_feedback === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(buf_power, 3'b000);
    rd(ADDR_REF_DIV_LOW, RST_REF_DIV_LOW);
    rd(ADDR_REF_DIV_HIGH, RST_REF_DIV_HIGH);
    rd(ADDR_PRESCALER, RST_PRESCALER);
    rd(ADDR_SYNC_DELAY, RST_SYNC_DELAY);
    rd(ADDR_REF_INPUT, RST_REF_INPUT);
    rd(ADDR_REF_SELECT, RST_REF_SELECT);
    wr(10'h013, 8'hFF);
    rd(10'h013, 8'h00);
    wr(ADDR_SYNC_DELAY, 8'h2D);
    rd(ADDR_SYNC_DELAY, 8'h2D);
    wr(ADDR_SYNC_DELAY, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_power;
    wr(ADDR_REF_INPUT, 8'h07);
    tick(2);
    chk(buf_power, 3'b100);
    wr(ADDR_REF_INPUT, 8'h00);
    tick(2);
    chk(buf_power, 3'b011);
    pll_power_down <= 1'b1;
    tick(3);
    chk(buf_power, 3'b000);
    pll_power_down <= 1'b0;
    wr(ADDR_REF_INPUT, 8'h02);
    tick(2);
    chk(buf_power, 3'b001);
    $display("test power done");
  endtask

  task automatic t_manual;
    wr(ADDR_REF_INPUT, 8'h00);
    wr(ADDR_REF_SELECT, 8'h08);
    wait_for(0, 1'b1, 40);
    wr(ADDR_REF_SELECT, 8'h02);
    wait_for(0, 1'b0, 40);
    ref_select_pin <= 1'b1;
    wait_for(0, 1'b1, 40);
    ref_select_pin <= 1'b0;
    wait_for(0, 1'b0, 40);
    sec_en <= 1'b0;
    tick(10);
    ref_select_pin <= 1'b1;
    tick(40);
    chk(active_is_secondary, 1'b0);
    wr(ADDR_REF_INPUT, 8'h80);
    wait_for(0, 1'b1, 10);
    ref_select_pin <= 1'b0;
    wr(ADDR_REF_INPUT, 8'h00);
    sec_en <= 1'b1;
    wait_for(0, 1'b0, 40);
    $display("test manual done");
  endtask

  task automatic t_auto;
    logic [7:0] md [2] = '{8'h50, 8'h18};
    wr(ADDR_REF_SELECT, 8'h00);
    wr(ADDR_REF_INPUT, 8'h10);
    prim_en <= 1'b0;
    wait_for(1, 1'b1, 40);
    wait_for(0, 1'b1, 20);
    prim_en <= 1'b1;
    wait_for(1, 1'b0, 60);
    wait_for(0, 1'b0, 40);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_REF_INPUT, md[i]);
      prim_en <= 1'b0;
      wait_for(0, 1'b1, 60);
      prim_en <= 1'b1;
      wait_for(1, 1'b0, 60);
      tick(100);
      chk(active_is_secondary, 1'b1);
      wr(ADDR_REF_INPUT, md[i] & 8'hEF);
      wr(ADDR_REF_SELECT, 8'h00);
      wr(ADDR_REF_INPUT, md[i]);
      wait_for(0, 1'b0, 40);
    end
    wr(ADDR_REF_INPUT, 8'h00);
    $display("test auto done");
  endtask

  task automatic t_rdiv;
    int n;
    period(1'b0, n);
    chk(n, 2 * PH);
    wr(ADDR_REF_DIV_LOW, 8'h00);
    wr(ADDR_REF_DIV_HIGH, 8'h00);
    period(1'b0, n);
    chk(n, 2 * PH);
    wr(ADDR_REF_DIV_LOW, 8'h03);
    period(1'b0, n);
    chk(n, 2 * PH);
    wr(ADDR_REF_DIV_HIGH, 8'h00);
    period(1'b0, n);
    chk(n, 6 * PH);
    wr(ADDR_REF_DIV_LOW, 8'h00);
    wr(ADDR_REF_DIV_HIGH, 8'h01);
    period(1'b0, n);
    chk(n, 512 * PH);
    wr(ADDR_REF_DIV_LOW, 8'h01);
    wr(ADDR_REF_DIV_HIGH, 8'h00);
    $display("test rdiv done");
  endtask

  task automatic t_fb;
    int n;
    int e;
    int pv [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_PRESCALER, 8'(m));
      period(1'b1, n);
      e = 2 * VH * (pv[m] * 3 + int'(m >= 2 && m <= 6));
      chk(n, e);
    end
    a_count <= 6'h00;
    wr(ADDR_PRESCALER, 8'h02);
    period(1'b1, n);
    chk(n, 2 * VH * 6);
    wr(ADDR_PRESCALER, 8'h09);
    period(1'b1, n);
    chk(n, 2 * VH * 2);
    $display("test fb done");
  endtask

  task automatic t_sync;
    int r;
    wr(ADDR_PRESCALER, 8'h80);
    tick(20);
    pulses(r);
    chk(r, 0);
    wr(ADDR_PRESCALER, 8'h00);
    wr(ADDR_SYNC_DELAY, 8'hC0);
    sync_n <= 1'b0;
    tick(20);
    pulses(r);
    chk(r, 0);
    wr(ADDR_SYNC_DELAY, 8'h00);
    tick(20);
    pulses(r);
    chk(r != 0, 1'b1);
    sync_n <= 1'b1;
    wr(ADDR_REF_SELECT, 8'h01);
    chk(cp_high_z, 1'b0);
    sync_n <= 1'b0;
    tick(3);
    chk(cp_high_z, 1'b1);
    sync_n <= 1'b1;
    wait_for(2, 1'b0, 40);
    $display("test sync done");
  endtask

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    pll_power_down = 1'b0;
    ref_select_pin = 1'b0;
    sync_n = 1'b1;
    prim_en = 1'b1;
    sec_en = 1'b1;
    a_count = 6'h01;
    b_count = 13'h0003;
    error_cnt = 0;
    n_checks = 0;
    tick(16);
    srst <= 1'b0;
    tick(1);
    t_regs();
    t_power();
    t_manual();
    t_auto();
    t_rdiv();
    t_fb();
    t_sync();
    wrap_up();
  end
endmodule

bind pll_ref_select_and_dividers pll_ref_monitor mon_u (.*);

// [verification/ref_clk_model.sv]
`timescale 1ns/1ps
module ref_clk_model #(
  parameter int PH = 3, // Primary half period
  parameter int SH = 4, // Secondary half period
  parameter int VH = 2  // Feedback half period
) (
  input  wire logic clock,               // Clock
  input  wire logic prim_en,             // Primary runs
  input  wire logic sec_en,              // Secondary runs
  output logic      primary_reference,   // Primary
  output logic      secondary_reference, // Secondary
  output logic      vco_clock            // Feedback
);
  int pc = 0;
  int sc = 0;
  int vc = 0;

  // A lost source freezes at its last level like a dead oscillator
  always @(posedge clock) begin
    if (prim_en) begin
      pc <= (pc == 2 * PH - 1) ? 0 : pc + 1;
    end
    if (sec_en) begin
      sc <= (sc == 2 * SH - 1) ? 0 : sc + 1;
    end
    vc <= (vc == 2 * VH - 1) ? 0 : vc + 1;
  end

  assign primary_reference   = (pc >= PH);
  assign secondary_reference = (sc >= SH);
  assign vco_clock           = (vc >= VH);
endmodule

// [verilog/edge_sense.sv]
`timescale 1ns/1ps
module edge_sense #(
  parameter int WIDTH = 4
) (
  input  logic             clock, // System clock
  input  logic             srst,  // Synchronous reset
  input  logic [WIDTH-1:0] lvl,   // Sampled levels
  output logic [WIDTH-1:0] rise,  // Rising edge this cycle
  output logic [WIDTH-1:0] fall   // Falling edge this cycle
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  always_comb begin
    prev_d = lvl;
    rise   = lvl & ~prev_q;
    fall   = ~lvl & prev_q;
  end

  // All-ones at reset so an active-low pin held high gives no false edge
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_q <= '1;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

// [verilog/pll_ref_pkg.sv]
package pll_ref_pkg;

  localparam int ADDR_W = 10;

  // Register offsets
  localparam logic [9:0] ADDR_REF_DIV_LOW   = 10'h011;
  localparam logic [9:0] ADDR_REF_DIV_HIGH  = 10'h012;
  localparam logic [9:0] ADDR_PRESCALER     = 10'h016;
  localparam logic [9:0] ADDR_SYNC_DELAY    = 10'h019;
  localparam logic [9:0] ADDR_REF_INPUT     = 10'h01C;
  localparam logic [9:0] ADDR_REF_SELECT    = 10'h01D;

  // Reset values: every reference buffer starts powered down
  localparam logic [7:0] RST_REF_DIV_LOW    = 8'h01;
  localparam logic [7:0] RST_REF_DIV_HIGH   = 8'h00;
  localparam logic [7:0] RST_PRESCALER      = 8'h06;
  localparam logic [7:0] RST_SYNC_DELAY     = 8'h00;
  localparam logic [7:0] RST_REF_INPUT      = 8'h06;
  localparam logic [7:0] RST_REF_SELECT     = 8'h00;

  // prescaler_control fields
  localparam int PRE_MODE_LSB  = 0;
  localparam int PRE_B_BYPASS  = 3;
  localparam int PRE_CNT_RESET = 7;
  // counter_sync_and_delay fields
  localparam int SYN_R_DLY_LSB = 0;
  localparam int SYN_N_DLY_LSB = 3;
  localparam int SYN_PIN_LSB   = 6;
  // reference_input_control fields
  localparam int RIC_DIFF_SEL  = 0;
  localparam int RIC_PRIM_PD   = 1;
  localparam int RIC_SEC_PD    = 2;
  localparam int RIC_REVERT_DIS = 3;
  localparam int RIC_AUTO_EN   = 4;
  localparam int RIC_STAY_SEC  = 6;
  localparam int RIC_DEGL_DIS  = 7;
  // reference_select_holdover fields (bits 7:6 read back status)
  localparam int RSH_HOLD_EN   = 0;
  localparam int RSH_USE_PIN   = 1;
  localparam int RSH_AUTO_HOLD = 2;
  localparam int RSH_MAN_SEC   = 3;
  localparam int RSH_ST_MISS   = 6;
  localparam int RSH_ST_SEC    = 7;

  // Monitor thresholds
  localparam logic [1:0] MISS_FALLS   = 2'h2;
  localparam logic [2:0] RETURN_RISES = 3'h4;

  typedef enum logic [2:0] {
    PRE_FD1  = 3'b000,
    PRE_FD2  = 3'b001,
    PRE_DM2  = 3'b010,
    PRE_DM4  = 3'b011,
    PRE_DM8  = 3'b100,
    PRE_DM16 = 3'b101,
    PRE_DM32 = 3'b110,
    PRE_FD3  = 3'b111
  } presc_mode_t;

  typedef enum logic [1:0] {
    SW_IDLE      = 2'b00,
    SW_WAIT_LOW  = 2'b01,
    SW_WAIT_RISE = 2'b10
  } sw_state_t;

  typedef struct packed {
    logic prim;
    logic sec;
    logic vco;
    logic sync_n;
  } pin_set_t;

  typedef struct packed {
    logic diff;
    logic prim;
    logic sec;
  } buf_power_t;

  typedef struct packed {
    logic [7:0] sreg;
    logic       q;
  } delay_state_t;

  typedef struct packed {
    logic [7:0]  div_low;
    logic [7:0]  div_high;
    logic [13:0] r_active;
    logic [7:0]  presc;
    logic [7:0]  sync_dly;
    logic [7:0]  ref_ctl;
    logic [7:0]  sel_hold;
    logic [7:0]  rdata;
    buf_power_t  pwr;
    sw_state_t   sw;
    logic        active_sec;
    logic        auto_sec;
    logic        missing;
    logic [1:0]  sec_falls;
    logic [2:0]  prim_rises;
    logic [13:0] r_cnt;
    logic        r_pulse;
    logic [5:0]  pre_cnt;
    logic [5:0]  a_left;
    logic [12:0] b_left;
    logic        fb_pulse;
    logic        cp_hiz;
  } top_state_t;

  function automatic logic [5:0] presc_p(input logic [2:0] m);
    case (m)
      PRE_FD1:  presc_p = 6'h01;
      PRE_FD2:  presc_p = 6'h02;
      PRE_DM2:  presc_p = 6'h02;
      PRE_DM4:  presc_p = 6'h04;
      PRE_DM8:  presc_p = 6'h08;
      PRE_DM16: presc_p = 6'h10;
      PRE_DM32: presc_p = 6'h20;
      default:  presc_p = 6'h03;
    endcase
  endfunction

  function automatic logic presc_dual(input logic [2:0] m);
    presc_dual = (m != PRE_FD1) && (m != PRE_FD2) && (m != PRE_FD3);
  endfunction

endpackage

// [verilog/pll_ref_select_and_dividers.sv]
`timescale 1ns/1ps
module pll_ref_select_and_dividers (
  input  logic                       clock,          // 50 MHz system clock
  input  logic                       srst,           // Sync reset, high
  input  logic                       reg_wr,         // Register write strobe
  input  logic                       reg_rd,         // Register read strobe
  input  logic [pll_ref_pkg::ADDR_W-1:0] reg_addr,   // Register offset
  input  logic [7:0]                 reg_wdata,      // Write data
  output logic [7:0]                 reg_rdata,      // Read data, next cycle
  input  logic                       pll_power_down, // PLL powered down
  input  logic                       primary_reference,   // Primary ref level
  input  logic                       secondary_reference, // Secondary level
  input  logic                       ref_select_pin, // 1 selects secondary
  input  logic                       vco_clock,      // VCO/ext clock level
  input  logic                       sync_n,         // Alignment pin, low
  input  logic [5:0]                 a_count,        // A counter value
  input  logic [12:0]                b_count,        // B counter value
  output pll_ref_pkg::buf_power_t    buf_power,      // Buffer power enables
  output logic                       active_is_secondary, // Active reference
  output logic                       primary_missing,     // Monitor flag
  output logic                       pfd_reference,  // Delayed R output pulse
  output logic                       pfd_feedback,   // Delayed N output pulse
  output logic                       cp_high_z       // Charge pump held off
);
  import pll_ref_pkg::*;

  top_state_t s_q;
  top_state_t s_d;
  pin_set_t   pins;
  pin_set_t   rise;
  pin_set_t   fall;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges

  always_comb begin
    pins.prim   = primary_reference & (s_q.pwr.prim | s_q.pwr.diff);
    pins.sec    = secondary_reference & s_q.pwr.sec;
    pins.vco    = vco_clock;
    pins.sync_n = sync_n;
  end

  edge_sense #(
    .WIDTH(4)
  ) u_edges (
    .clock(clock),
    .srst (srst),
    .lvl  (pins),
    .rise (rise),
    .fall (fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        diff_sel;
  logic        auto_en;
  logic        req_sec;
  logic        tgt_lvl;
  logic        tgt_rise;
  logic        ref_edge;
  logic        cnt_reset;
  logic        b_reload;
  logic [13:0] r_last;
  logic [5:0]  p_val;
  logic [5:0]  p_mod;
  logic        dual;
  logic [12:0] b_eff;
  logic [5:0]  a_eff;
  logic [2:0]  falls_sum;

  always_comb begin
    s_d       = s_q;
    s_d.r_pulse  = 1'b0;
    s_d.fb_pulse = 1'b0;
    diff_sel  = s_q.ref_ctl[RIC_DIFF_SEL];
    auto_en   = s_q.ref_ctl[RIC_AUTO_EN] & ~diff_sel;
    tgt_lvl   = 1'b0;
    tgt_rise  = 1'b0;
    ref_edge  = 1'b0;
    b_reload  = 1'b0;
    falls_sum = 3'h0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_REF_DIV_LOW:  s_d.div_low  = reg_wdata;
        ADDR_REF_DIV_HIGH: begin
          s_d.div_high = {2'b00, reg_wdata[5:0]};
          // High byte commits the pair so the divider never sees half
          s_d.r_active = {reg_wdata[5:0], s_q.div_low};
        end
        ADDR_PRESCALER:    s_d.presc    = reg_wdata;
        ADDR_SYNC_DELAY:   s_d.sync_dly = reg_wdata;
        ADDR_REF_INPUT:    s_d.ref_ctl  = reg_wdata;
        ADDR_REF_SELECT:   s_d.sel_hold = {2'b00, reg_wdata[5:0]};
        default: begin
        end
      endcase
    end

    // Register reads, unmapped offsets read zero
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_REF_DIV_LOW:  s_d.rdata = s_q.div_low;
        ADDR_REF_DIV_HIGH: s_d.rdata = s_q.div_high;
        ADDR_PRESCALER:    s_d.rdata = s_q.presc;
        ADDR_SYNC_DELAY:   s_d.rdata = s_q.sync_dly;
        ADDR_REF_INPUT:    s_d.rdata = s_q.ref_ctl;
        ADDR_REF_SELECT: begin
          s_d.rdata = s_q.sel_hold;
          s_d.rdata[RSH_ST_MISS] = s_q.missing;
          s_d.rdata[RSH_ST_SEC]  = s_q.active_sec;
        end
        default: s_d.rdata = 8'h00;
      endcase
    end

    // Buffer power; reset values hold both single-ended buffers off
    s_d.pwr.diff = ~pll_power_down & diff_sel;
    s_d.pwr.prim = ~pll_power_down & ~diff_sel
                   & ~s_q.ref_ctl[RIC_PRIM_PD];
    s_d.pwr.sec  = ~pll_power_down & ~diff_sel
                   & ~s_q.ref_ctl[RIC_SEC_PD];

    ////////////////////////////////////////////////////////////////////////
    // Primary monitor, clocked by secondary falls and primary edges

    if (!auto_en) begin
      s_d.missing    = 1'b0;
      s_d.auto_sec   = 1'b0;
      s_d.sec_falls  = 2'h0;
      s_d.prim_rises = 3'h0;
    end else begin
      falls_sum = {1'b0, s_q.sec_falls} + {2'b00, fall.sec};
      if (rise.prim || fall.prim) begin
        s_d.sec_falls = {1'b0, fall.sec};
      end else if (falls_sum >= {1'b0, MISS_FALLS}) begin
        s_d.sec_falls = MISS_FALLS;
      end else begin
        s_d.sec_falls = falls_sum[1:0];
      end
      if (!s_q.missing) begin
        if (s_d.sec_falls == MISS_FALLS) begin
          s_d.missing    = 1'b1;
          s_d.auto_sec   = 1'b1;
          s_d.prim_rises = 3'h0;
        end
      end else if (s_d.sec_falls == MISS_FALLS && !rise.prim) begin
        s_d.prim_rises = 3'h0;
      end else if (rise.prim) begin
        s_d.prim_rises = s_q.prim_rises + 3'h1;
        if (s_d.prim_rises == RETURN_RISES) begin
          s_d.missing    = 1'b0;
          s_d.prim_rises = 3'h0;
          s_d.sec_falls  = 2'h0;
          // Stay mode or revert-disable keep the secondary latched;
          // software leaves auto mode to get back
          if (!s_q.ref_ctl[RIC_STAY_SEC]
              && !s_q.ref_ctl[RIC_REVERT_DIS]) begin
            s_d.auto_sec = 1'b0;
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switchover with deglitch

    if (diff_sel) begin
      req_sec = 1'b0;
    end else if (auto_en) begin
      req_sec = s_q.auto_sec;
    end else if (s_q.sel_hold[RSH_USE_PIN]) begin
      req_sec = ref_select_pin;
    end else begin
      req_sec = s_q.sel_hold[RSH_MAN_SEC];
    end
    tgt_lvl  = req_sec ? pins.sec : pins.prim;
    tgt_rise = req_sec ? rise.sec : rise.prim;

    case (s_q.sw)
      SW_IDLE: begin
        ref_edge = s_q.active_sec ? rise.sec : rise.prim;
        if (req_sec != s_q.active_sec) begin
          if (s_q.ref_ctl[RIC_DEGL_DIS]) begin
            s_d.active_sec = req_sec;
          end else begin
            s_d.sw   = SW_WAIT_LOW;
            ref_edge = 1'b0;
          end
        end
      end
      SW_WAIT_LOW: begin
        // Old reference is blocked; a target stuck high never switches
        if (req_sec == s_q.active_sec || s_q.ref_ctl[RIC_DEGL_DIS]) begin
          s_d.sw = SW_IDLE;
        end else if (!tgt_lvl) begin
          s_d.sw = SW_WAIT_RISE;
        end
      end
      SW_WAIT_RISE: begin
        if (req_sec == s_q.active_sec || s_q.ref_ctl[RIC_DEGL_DIS]) begin
          s_d.sw = SW_IDLE;
        end else if (tgt_rise) begin
          s_d.active_sec = req_sec;
          s_d.sw         = SW_IDLE;
          ref_edge       = 1'b1;
        end
      end
      default: s_d.sw = SW_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Counter resets and manual holdover

    cnt_reset = s_q.presc[PRE_CNT_RESET]
                | ((s_q.sync_dly[SYN_PIN_LSB +: 2] != 2'b00)
                   & ~sync_n);

    if (fall.sync_n && s_q.sel_hold[RSH_HOLD_EN]) begin
      s_d.cp_hiz = 1'b1;
    end else if (s_q.cp_hiz && sync_n && s_q.r_pulse) begin
      // Leave on the reference-path event and realign B with it
      s_d.cp_hiz = 1'b0;
      b_reload   = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference divider

    r_last = (s_q.r_active <= 14'h0001) ? 14'h0000
             : s_q.r_active - 14'h0001;
    if (cnt_reset) begin
      s_d.r_cnt = 14'h0000;
    end else if (ref_edge) begin
      if (s_q.r_cnt >= r_last) begin
        s_d.r_cnt   = 14'h0000;
        s_d.r_pulse = 1'b1;
      end else begin
        s_d.r_cnt = s_q.r_cnt + 14'h0001;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Feedback divider: prescaler with A and B counters

    p_val = presc_p(s_q.presc[PRE_MODE_LSB +: 3]);
    dual  = presc_dual(s_q.presc[PRE_MODE_LSB +: 3]);
    // Bypass is only meaningful with a fixed-divide prescaler
    b_eff = s_q.presc[PRE_B_BYPASS] ? 13'h0001 : b_count;
    a_eff = dual ? a_count : 6'h00;
    p_mod = (dual && s_q.a_left != 6'h00) ? p_val + 6'h01 : p_val;

    if (cnt_reset) begin
      s_d.a_left = a_eff;
      s_d.b_left = b_eff;
    end else if (b_reload) begin
      // Prescaler keeps its phase on purpose
      s_d.a_left = a_eff;
      s_d.b_left = b_eff;
    end else if (rise.vco) begin
      if (s_q.pre_cnt >= p_mod - 6'h01) begin
        s_d.pre_cnt = 6'h00;
        // A prescaler cycles at P+1, then B-A at P: N = P*B + A
        if (s_q.b_left <= 13'h0001) begin
          s_d.b_left   = b_eff;
          s_d.a_left   = a_eff;
          s_d.fb_pulse = 1'b1;
        end else begin
          s_d.b_left = s_q.b_left - 13'h0001;
          if (s_q.a_left != 6'h00) begin
            s_d.a_left = s_q.a_left - 6'h01;
          end
        end
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q            <= '0;
      s_q.div_low    <= RST_REF_DIV_LOW;
      s_q.div_high   <= RST_REF_DIV_HIGH;
      s_q.r_active   <= {RST_REF_DIV_HIGH[5:0], RST_REF_DIV_LOW};
      s_q.presc      <= RST_PRESCALER;
      s_q.sync_dly   <= RST_SYNC_DELAY;
      s_q.ref_ctl    <= RST_REF_INPUT;
      s_q.sel_hold   <= RST_REF_SELECT;
      s_q.sw         <= SW_IDLE;
      s_q.b_left     <= 13'h0001;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay cells, steps of one clock

  pulse_delay u_ref_delay (
    .clock(clock),
    .srst (srst),
    .din  (s_q.r_pulse),
    .sel  (s_q.sync_dly[SYN_R_DLY_LSB +: 3]),
    .dout (pfd_reference)
  );

  pulse_delay u_fb_delay (
    .clock(clock),
    .srst (srst),
    .din  (s_q.fb_pulse),
    .sel  (s_q.sync_dly[SYN_N_DLY_LSB +: 3]),
    .dout (pfd_feedback)
  );

  assign reg_rdata           = s_q.rdata;
  assign buf_power           = s_q.pwr;
  assign active_is_secondary = s_q.active_sec;
  assign primary_missing     = s_q.missing;
  assign cp_high_z           = s_q.cp_hiz;

endmodule

// [verilog/pulse_delay.sv]
`timescale 1ns/1ps
module pulse_delay (
  input  logic       clock, // System clock
  input  logic       srst,  // Synchronous reset
  input  logic       din,   // Divider output pulse
  input  logic [2:0] sel,   // Delay step, 0 is shortest
  output logic       dout   // Delayed pulse, registered
);
  import pll_ref_pkg::*;

  delay_state_t s_q;
  delay_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.sreg = {s_q.sreg[6:0], din};
    s_d.q    = s_d.sreg[sel];
    dout     = s_q.q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
